// [logic/fruit_mbox_pkg.sv]
package fruit_mbox_pkg;

  // ----------------------------------------------------------------
  // Data path sizes
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int DEPTH  = 16;
  localparam int ADDR_W = 4;

  // The address rings only walk 4..7, one group of four words
  localparam logic [ADDR_W-1:0] ADDR_FIRST = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_LAST  = 4'h7;

  // ----------------------------------------------------------------
  // Operating modes, Gray ordered
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL     = 2'b00,
    MODE_GEN_DIAG   = 2'b01,
    MODE_ATTEN_DIAG = 2'b11,
    MODE_LOOP       = 2'b10
  } mode_t;

  localparam mode_t MODE_RESET = MODE_NORMAL;

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_STATUS = 12'h000;
  localparam logic [11:0] REG_MODE   = 12'h004;

  // Status word fields
  localparam int STAT_OUT_BIT      = 0;
  localparam int STAT_IN_BIT       = 1;
  localparam int STAT_MODE_LSB     = 2;
  localparam int STAT_OUT_ADDR_LSB = 4;
  localparam int STAT_IN_ADDR_LSB  = 8;
  localparam int STAT_READ_ACT     = 12;
  localparam int STAT_WRITE_ACT    = 13;

  // Controller status pins: {mode[1:0], in_status, out_status}
  localparam int CSTAT_W = 4;

endpackage : fruit_mbox_pkg

// [logic/io_edge_detect.sv]
`timescale 1ns/1ns
module io_edge_detect (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic level_in,
  output logic      rise_pulse,
  output logic      fall_pulse
);

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;

  // First stage feeds only the second one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else if (clk_en) begin
      sync1_reg <= level_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_pulse <= 1'b0;
      fall_pulse <= 1'b0;
    end else if (clk_en) begin
      rise_pulse <= sync2_reg & ~prev_reg;
      fall_pulse <= ~sync2_reg & prev_reg;
    end
  end

endmodule : io_edge_detect

// [logic/addr_ring.sv]
`timescale 1ns/1ns
module addr_ring (
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic                               clk_en,
  input  wire logic                               init,
  input  wire logic                               step,
  output logic [fruit_mbox_pkg::ADDR_W-1:0]       addr,
  output logic                                    wrap
);

  // Wrap marks the step that leaves the last word of the group
  assign wrap = step && (addr == fruit_mbox_pkg::ADDR_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr <= fruit_mbox_pkg::ADDR_FIRST;
    end else if (clk_en) begin
      if (init || wrap) begin
        addr <= fruit_mbox_pkg::ADDR_FIRST;
      end else if (step) begin
        addr <= addr + 4'h1;
      end
    end
  end

endmodule : addr_ring

// [logic/fruit_param_mailbox_interface.sv]
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ns
module fruit_param_mailbox_interface (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                clk_en,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [11:0]                         paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic                                host_data_out_pulse,
  input  wire logic                                host_data_in_pulse,
  input  wire logic                                host_control_out_instr,
  input  wire logic                                host_io_reset,
  input  wire logic                                host_io_pulse,
  input  wire logic [fruit_mbox_pkg::WORD_W-1:0]   host_wdata,
  output logic      [fruit_mbox_pkg::WORD_W-1:0]   host_rdata,
  input  wire logic                                ctrl_read_pulse,
  input  wire logic                                ctrl_write_pulse,
  input  wire logic [fruit_mbox_pkg::WORD_W-1:0]   ctrl_wdata,
  output logic      [fruit_mbox_pkg::WORD_W-1:0]   ctrl_rdata,
  output logic                                     read_window_output,
  output logic                                     write_window_output,
  input  wire logic                                ctrl_stat_examine,
  output logic      [fruit_mbox_pkg::CSTAT_W-1:0]  ctrl_stat_o,
  output logic      [fruit_mbox_pkg::CSTAT_W-1:0]  ctrl_stat_oe_n
);

  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  logic [fruit_mbox_pkg::WORD_W-1:0] out_mem [fruit_mbox_pkg::DEPTH];
  logic [fruit_mbox_pkg::WORD_W-1:0] in_mem  [fruit_mbox_pkg::DEPTH];
  fruit_mbox_pkg::mode_t             mode_reg;
  logic                              out_status_reg;
  logic                              in_status_reg;
  logic [fruit_mbox_pkg::ADDR_W-1:0] out_addr;
  logic [fruit_mbox_pkg::ADDR_W-1:0] in_addr;
  logic                              out_wrap;
  logic                              in_wrap;
  logic                              out_rise;
  logic                              out_fall;
  logic                              in_rise;
  logic                              in_fall;
  logic                              ctl_rise;
  logic                              ctl_fall;
  logic                              host_init;
  logic                              loop_mode;
  logic                              gen_mode;
  logic                              host_wr_ok;
  logic                              out_step;
  logic                              in_step;
  logic                              host_in_ok;
  logic                              apb_access;
  logic                              apb_mode_wr;
  logic [fruit_mbox_pkg::WORD_W-1:0] out_word;

  // ----------------------------------------------------------------
  // Host pulse edge detection
  // ----------------------------------------------------------------
  io_edge_detect u_edge_dout (
    .pclk       (pclk),
    .presetn    (presetn),
    .clk_en     (clk_en),
    .level_in   (host_data_out_pulse),
    .rise_pulse (out_rise),
    .fall_pulse (out_fall)
  );

  io_edge_detect u_edge_din (
    .pclk       (pclk),
    .presetn    (presetn),
    .clk_en     (clk_en),
    .level_in   (host_data_in_pulse),
    .rise_pulse (in_rise),
    .fall_pulse (in_fall)
  );

  io_edge_detect u_edge_ctl (
    .pclk       (pclk),
    .presetn    (presetn),
    .clk_en     (clk_en),
    .level_in   (host_control_out_instr),
    .rise_pulse (ctl_rise),
    .fall_pulse (ctl_fall)
  );

  // ----------------------------------------------------------------
  // Mode decoding
  // ----------------------------------------------------------------
  assign host_init  = host_io_reset | host_io_pulse;
  assign loop_mode  = (mode_reg == fruit_mbox_pkg::MODE_LOOP);
  assign gen_mode   = (mode_reg == fruit_mbox_pkg::MODE_GEN_DIAG);
  // Loop test ignores ownership since the controller stays out
  assign host_wr_ok = out_rise && (loop_mode || !out_status_reg);
  assign host_in_ok = in_fall && (loop_mode || (gen_mode && in_status_reg));
  assign out_step   = (out_fall && (loop_mode || !out_status_reg)) || read_window_output;
  assign in_step    = write_window_output || host_in_ok || (loop_mode && out_fall);

  addr_ring u_out_ring (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .init    (host_init),
    .step    (out_step),
    .addr    (out_addr),
    .wrap    (out_wrap)
  );

  addr_ring u_in_ring (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .init    (host_init),
    .step    (in_step),
    .addr    (in_addr),
    .wrap    (in_wrap)
  );

  // ----------------------------------------------------------------
  // Mode register: host control instruction or APB
  // ----------------------------------------------------------------
  assign apb_access  = psel && penable && !pready;
  assign apb_mode_wr = psel && penable && pready && pwrite && (paddr == fruit_mbox_pkg::REG_MODE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= fruit_mbox_pkg::MODE_RESET;
    end else if (clk_en) begin
      if (ctl_rise) begin
        mode_reg <= fruit_mbox_pkg::mode_t'(host_wdata[1:0]);
      end else if (apb_mode_wr) begin
        mode_reg <= fruit_mbox_pkg::mode_t'(pwdata[1:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Outbound channel
  // ----------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (clk_en && host_wr_ok) begin
      out_mem[out_addr] <= host_wdata;
    end
  end

  // A group stays with one owner until all four words moved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_status_reg <= 1'b0;
    end else if (clk_en) begin
      if (host_init) begin
        out_status_reg <= 1'b0;
      end else if (read_window_output && out_wrap) begin
        out_status_reg <= 1'b0;
      end else if (!loop_mode && !out_status_reg && out_fall && out_wrap) begin
        out_status_reg <= 1'b1;
      end
    end
  end

  // Controller read window: one word per clock, four clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_window_output <= 1'b0;
    end else if (clk_en) begin
      if (host_init || out_wrap) begin
        read_window_output <= 1'b0;
      end else if (ctrl_read_pulse && out_status_reg && !loop_mode) begin
        read_window_output <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_rdata <= '0;
    end else if (clk_en && read_window_output) begin
      ctrl_rdata <= out_mem[out_addr];
    end
  end

  // ----------------------------------------------------------------
  // Inbound channel
  // ----------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (clk_en) begin
      if (loop_mode && out_rise) begin
        in_mem[in_addr] <= host_wdata;
      end else if (write_window_output) begin
        in_mem[in_addr] <= ctrl_wdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_window_output <= 1'b0;
    end else if (clk_en) begin
      if (host_init || (write_window_output && in_wrap)) begin
        write_window_output <= 1'b0;
      end else if (ctrl_write_pulse && gen_mode && !in_status_reg) begin
        write_window_output <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_status_reg <= 1'b0;
    end else if (clk_en) begin
      if (host_init) begin
        in_status_reg <= 1'b0;
      end else if (write_window_output && in_wrap) begin
        in_status_reg <= 1'b1;
      end else if (!loop_mode && host_in_ok && in_wrap) begin
        in_status_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_rdata <= '0;
    end else if (clk_en) begin
      host_rdata <= in_mem[in_addr];
    end
  end

  // ----------------------------------------------------------------
  // Controller status pins, open collector
  // ----------------------------------------------------------------
  // Pulls low only; a one is left to the bus pull-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_stat_o    <= '0;
      ctrl_stat_oe_n <= '1;
    end else if (clk_en) begin
      ctrl_stat_o <= '0;
      if (ctrl_stat_examine) begin
        ctrl_stat_oe_n <= {mode_reg, in_status_reg, out_status_reg};
      end else begin
        ctrl_stat_oe_n <= '1;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (clk_en) begin
      pready  <= apb_access;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (apb_access) begin
        unique case (paddr)
          fruit_mbox_pkg::REG_STATUS: begin
            if (!pwrite) begin
              prdata[fruit_mbox_pkg::STAT_OUT_BIT]                               <= out_status_reg;
              prdata[fruit_mbox_pkg::STAT_IN_BIT]                                <= in_status_reg;
              prdata[fruit_mbox_pkg::STAT_MODE_LSB +: 2]                         <= mode_reg;
              prdata[fruit_mbox_pkg::STAT_OUT_ADDR_LSB +: fruit_mbox_pkg::ADDR_W] <= out_addr;
              prdata[fruit_mbox_pkg::STAT_IN_ADDR_LSB +: fruit_mbox_pkg::ADDR_W]  <= in_addr;
              prdata[fruit_mbox_pkg::STAT_READ_ACT]                              <= read_window_output;
              prdata[fruit_mbox_pkg::STAT_WRITE_ACT]                             <= write_window_output;
            end
          end
          fruit_mbox_pkg::REG_MODE: begin
            prdata[1:0] <= mode_reg;
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !clk_en);
  assign out_word = out_mem[out_addr];

  property p_addr_range;
    (out_addr >= fruit_mbox_pkg::ADDR_FIRST) && (out_addr <= fruit_mbox_pkg::ADDR_LAST) &&
    (in_addr >= fruit_mbox_pkg::ADDR_FIRST) && (in_addr <= fruit_mbox_pkg::ADDR_LAST);
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("address outside 4..7");

  property p_grant;
    (!host_init && !loop_mode && !out_status_reg && out_fall && out_addr == fruit_mbox_pkg::ADDR_LAST)
      |=> out_status_reg && (out_addr == fruit_mbox_pkg::ADDR_FIRST);
  endproperty
  a_grant: assert property (p_grant) else $error("fourth write did not grant controller");

  property p_window;
    $rose(read_window_output) && !host_init |-> read_window_output [*4] ##1 !read_window_output;
  endproperty
  a_window: assert property (p_window) else $error("read window not four cycles");

  property p_release;
    $fell(read_window_output) && !$past(host_init) |-> !out_status_reg && out_addr == fruit_mbox_pkg::ADDR_FIRST;
  endproperty
  a_release: assert property (p_release) else $error("ownership not returned after read");

  property p_host_init;
    host_init |=> !out_status_reg && !in_status_reg && out_addr == fruit_mbox_pkg::ADDR_FIRST;
  endproperty
  a_host_init: assert property (p_host_init) else $error("host reset did not initialise");

  property p_ignore;
    out_rise && out_status_reg && !loop_mode |=> out_mem[$past(out_addr)] == $past(out_word);
  endproperty
  a_ignore: assert property (p_ignore) else $error("host write accepted while controller owns");

  property p_loop_copy;
    loop_mode && out_rise |=> in_mem[$past(in_addr)] == $past(host_wdata);
  endproperty
  a_loop_copy: assert property (p_loop_copy) else $error("loop copy missing");

  property p_mode_load;
    ctl_rise |=> mode_reg == $past(host_wdata[1:0]);
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode not loaded");

  property p_one_clock;
    out_rise |=> !out_rise;
  endproperty
  a_one_clock: assert property (p_one_clock) else $error("edge pulse wider than one clock");

  property p_gate;
    !ctrl_stat_examine |=> ctrl_stat_oe_n == '1;
  endproperty
  a_gate: assert property (p_gate) else $error("status driven while not examined");

endmodule : fruit_param_mailbox_interface

// [sim/ctrl_model.sv]
`timescale 1ns/1ns
// ------------------------------------------------------------
// Controller side: reads outbound groups, writes one inbound group
// ------------------------------------------------------------
module ctrl_model #(
  parameter int          GAP   = 8,
  parameter logic [15:0] WBASE = 16'hc0de
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        rd_go,
  input  wire logic        wr_go,
  input  wire logic [3:0]  stat_lvl,
  input  wire logic [15:0] ctrl_rdata,
  input  wire logic        read_window_output,
  input  wire logic        write_window_output,
  output logic             ctrl_stat_examine,
  output logic             ctrl_read_pulse,
  output logic             ctrl_write_pulse,
  output logic [15:0]      ctrl_wdata,
  output logic [15:0]      rx [4],
  output logic [3:0]       groups
);
  logic [3:0] hold_cnt;
  logic [1:0] k;
  logic       win_d;
  logic       ex_d;
  logic       wr_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_stat_examine <= 1'b0;
      ctrl_read_pulse   <= 1'b0;
      ctrl_write_pulse  <= 1'b0;
      ctrl_wdata        <= 16'h0000;
      groups            <= 4'h0;
      hold_cnt          <= 4'h0;
      k                 <= 2'h0;
      win_d             <= 1'b0;
      ex_d              <= 1'b0;
      wr_done           <= 1'b0;
      for (int i = 0; i < 4; i++) rx[i] <= 16'h0000;
    end else begin
      ctrl_stat_examine <= rd_go | wr_go;
      ex_d              <= ctrl_stat_examine;
      ctrl_read_pulse   <= 1'b0;
      ctrl_write_pulse  <= 1'b0;
      win_d             <= read_window_output;
      // Read data trails the window by one cycle
      if (win_d) begin
        rx[k] <= ctrl_rdata;
        k     <= k + 2'h1;
        if (k == 2'h3) groups <= groups + 4'h1;
      end
      // Data lines churn only while no write group is in flight and hold_cnt is zero
      if (write_window_output) ctrl_wdata <= ctrl_wdata + 16'h0001;
      else if (hold_cnt == 4'h0) ctrl_wdata <= ~ctrl_wdata;
      if (hold_cnt != 4'h0) hold_cnt <= hold_cnt - 4'h1;
      else if (ex_d && ctrl_stat_examine && rd_go && stat_lvl[0]) begin
        ctrl_read_pulse <= 1'b1;
        hold_cnt        <= 4'(GAP);
      end else if (ex_d && ctrl_stat_examine && wr_go && !wr_done
                   && stat_lvl[3:2] == 2'b01 && !stat_lvl[1]) begin
        ctrl_write_pulse <= 1'b1;
        ctrl_wdata       <= WBASE;
        wr_done          <= 1'b1;
        hold_cnt         <= 4'h8;
      end
    end
  end
endmodule : ctrl_model

// [sim/testbench.sv]
`timescale 1ns/1ns
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_go, wr_go, clk_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        host_data_out_pulse, host_data_in_pulse, host_control_out_instr, host_io_reset;
  logic [15:0] host_wdata, host_rdata, ctrl_wdata, ctrl_rdata;
  logic        ctrl_read_pulse, ctrl_write_pulse, read_window_output, write_window_output;
  logic        ctrl_stat_examine;
  logic [3:0]  ctrl_stat_o, ctrl_stat_oe_n, stat_lvl, groups;
  logic [15:0] rx [4];
  logic [15:0] w [4];
  int          bad_count, checks, win_cnt;

  // Open-collector pins float high unless pulled low
  assign stat_lvl = ctrl_stat_oe_n | ctrl_stat_o;

  fruit_param_mailbox_interface u_fruit_param_mailbox_interface (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .host_data_out_pulse(host_data_out_pulse),
    .host_data_in_pulse(host_data_in_pulse), .host_control_out_instr(host_control_out_instr),
    .host_io_reset(host_io_reset), .host_io_pulse(1'b0), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .ctrl_read_pulse(ctrl_read_pulse), .ctrl_write_pulse(ctrl_write_pulse),
    .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .read_window_output(read_window_output),
    .write_window_output(write_window_output), .ctrl_stat_examine(ctrl_stat_examine),
    .ctrl_stat_o(ctrl_stat_o), .ctrl_stat_oe_n(ctrl_stat_oe_n));

  ctrl_model #(.GAP(8), .WBASE(16'hc0de)) u_ctrl_model (
    .pclk(pclk), .presetn(presetn), .rd_go(rd_go), .wr_go(wr_go), .stat_lvl(stat_lvl),
    .ctrl_rdata(ctrl_rdata), .read_window_output(read_window_output),
    .write_window_output(write_window_output), .ctrl_stat_examine(ctrl_stat_examine),
    .ctrl_read_pulse(ctrl_read_pulse), .ctrl_write_pulse(ctrl_write_pulse),
    .ctrl_wdata(ctrl_wdata), .rx(rx), .groups(groups));

  always #5 pclk = ~pclk;
  always @(posedge pclk) if (read_window_output === 1'b1) win_cnt++;

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog bounds this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = pslverr === 1'b1 ? 32'hffff_ffff : prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic st(input logic [31:0] e);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk("status", e, rdat);
  endtask : st

  task automatic pin(input int which, input logic [15:0] d);
    @(posedge pclk);
    host_wdata <= d;
    if (which == 0) host_data_out_pulse <= 1'b1;
    if (which == 1) host_data_in_pulse <= 1'b1;
    if (which == 2) host_control_out_instr <= 1'b1;
    if (which == 3) host_io_reset <= 1'b1;
    repeat (5) @(posedge pclk);
    if (which == 1) chk("host_rdata", {16'h0000, d}, {16'h0000, host_rdata});
    host_data_out_pulse <= 1'b0; host_data_in_pulse <= 1'b0;
    host_control_out_instr <= 1'b0; host_io_reset <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask : pin

  task automatic print_verdict();
    if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  initial begin
    #300000;
    bad_count++;
    print_verdict();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    host_data_out_pulse = 0; host_data_in_pulse = 0; host_control_out_instr = 0;
    host_io_reset = 0; host_wdata = 0; rd_go = 0; wr_go = 0; bad_count = 0; checks = 0; clk_en = 1;
    w = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    st(32'h0000_0440);
    chk("pins released", 32'hf, {28'h0, stat_lvl});
    apb(1'b0, 12'h008, 32'h0); chk("unmapped", 32'hffff_ffff, rdat);
    for (int m = 3; m >= 0; m--) begin
      apb(1'b1, 12'h004, 32'(m)); apb(1'b0, 12'h004, 32'h0);
      chk("mode", 32'(m), rdat);
    end
    st(32'h0000_0440);
    for (int i = 0; i < 3; i++) pin(0, w[i]);
    st(32'h0000_0470);
    pin(0, w[3]);
    st(32'h0000_0441);
    pin(0, 16'hdead);
    st(32'h0000_0441);
    win_cnt = 0; rd_go <= 1'b1;
    while (groups == 4'h0) @(posedge pclk);
    for (int i = 0; i < 4; i++) chk("read word", {16'h0, w[i]}, {16'h0, rx[i]});
    chk("read window", 32'd4, 32'(win_cnt));
    st(32'h0000_0440);
    chk("pins examined", 32'h0, {28'h0, stat_lvl});
    rd_go <= 1'b0;
    pin(2, 16'h0001);
    apb(1'b0, 12'h004, 32'h0); chk("mode", 32'h1, rdat);
    wr_go <= 1'b1;
    while (write_window_output !== 1'b1) @(posedge pclk);
    repeat (8) @(posedge pclk);
    chk("pins gen", 32'h6, {28'h0, stat_lvl});
    st(32'h0000_0446);
    for (int i = 0; i < 4; i++) pin(1, 16'hc0de + 16'(i));
    st(32'h0000_0444);
    wr_go <= 1'b0;
    apb(1'b1, 12'h004, 32'h2);
    for (int i = 0; i < 4; i++) pin(0, ~w[i]);
    for (int i = 0; i < 4; i++) pin(1, ~w[i]);
    st(32'h0000_0448);
    apb(1'b1, 12'h004, 32'h0);
    pin(0, w[0]); pin(0, w[1]);
    pin(3, 16'h0000);
    st(32'h0000_0440);
    // A frozen block must not see a host write at all
    clk_en <= 1'b0;
    pin(0, w[2]);
    clk_en <= 1'b1;
    st(32'h0000_0440);
    print_verdict();
  end
endmodule : testbench
